/* shared/serdes_defines.svh */
// constants for the serial pixel deserializer: frame layout, timing, register map
`ifndef SERDES_DEFINES_SVH
`define SERDES_DEFINES_SVH

`define FRAME_BITS 30
`define FR_PAY_HI 28
`define FR_PAY_LO 2
`define FR_PAR_BIT 1
`define FR_BLUE0_BIT 5
`define PARITY_SENSE 1'b1

`define BITS_1LANE 5'h1e
`define BITS_2LANE 5'h0f
`define BITS_3LANE 5'h0a

`define PERIOD_W 8
`define CLK_PERIOD_PS 5000
`define LOSS_TIME_NS 500
`define LOSS_CYCLES 8'((`LOSS_TIME_NS * 1000) / `CLK_PERIOD_PS)

`define ADDR_W 12
`define REG_STATUS 12'h000
`define REG_MASK 12'h004
`define REG_MODE 12'h008
`define ST_W 2
`define ST_PARITY 0
`define ST_LOSS 1

`endif

/* shared/serdes_pkg.sv */
// types shared by the serial pixel deserializer modules
package serdes_pkg;
  typedef enum logic [2:0] {
    PM_SHUTDOWN = 3'h1,
    PM_STANDBY = 3'h2,
    PM_ACTIVE = 3'h4
  } power_mode_t;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic vsync;
    logic hsync;
    logic enable;
  } pixel_t;
endpackage

/* shared/status_if.sv */
// events and state passed from the receive core to the register block
interface status_if import serdes_pkg::*; ();
  logic parity_evt;
  logic loss_evt;
  power_mode_t mode;
  logic [1:0] lane_count;
  modport core (output parity_evt, output loss_evt, output mode, output lane_count);
  modport regs (input parity_evt, input loss_evt, input mode, input lane_count);
endinterface

/* rtl/bit_timer.sv */
// phase accumulator that places lane bit strobes across one measured pixel period
`include "serdes_defines.svh"
module bit_timer #(
  parameter int PW = `PERIOD_W
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic start,
  input wire logic [PW-1:0] period,
  input wire logic [4:0] bits_per_lane,
  output logic strobe,
  output logic last
);
  logic [PW:0] acc;
  logic [4:0] cnt;
  logic [PW:0] next_acc;
  logic [4:0] next_cnt;
  logic next_strobe;
  logic next_last;
  logic [PW+1:0] sum;

  // multiplies the pixel rate by the bits per lane; starting at half a period
  // puts each sample near the middle of its bit slot
  always_comb begin
    next_acc = acc;
    next_cnt = cnt;
    next_strobe = 1'b0;
    next_last = 1'b0;
    sum = (PW+2)'(acc) + (PW+2)'(bits_per_lane);
    if (cnt < bits_per_lane && period != '0) begin
      if (sum >= (PW+2)'(period)) begin
        next_acc = (PW+1)'(sum - (PW+2)'(period));
        next_strobe = 1'b1;
        next_cnt = 5'(cnt + 5'h01);
        next_last = (5'(cnt + 5'h01) == bits_per_lane);
      end else begin
        next_acc = (PW+1)'(sum);
      end
    end
    // with one lane the last strobe can share its cycle with the next start,
    // so the start only reloads the phase and never swallows that strobe
    if (start) begin
      next_acc = (PW+1)'(period >> 1);
      next_cnt = 5'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      acc <= '0;
      cnt <= 5'h00;
      strobe <= 1'b0;
      last <= 1'b0;
    end else begin
      acc <= next_acc;
      cnt <= next_cnt;
      strobe <= next_strobe;
      last <= next_last;
    end
  end
endmodule

/* rtl/apb_regs.sv */
// apb slave: sticky status, mask, mode readback and the interrupt line
`include "serdes_defines.svh"
module apb_regs
  import serdes_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  status_if.regs st
);
  logic [`ST_W-1:0] status;
  logic [`ST_W-1:0] mask;
  logic [`ST_W-1:0] next_status;
  logic [`ST_W-1:0] next_mask;
  logic [`ST_W-1:0] events;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;
  logic setup;
  logic wr;
  logic mapped;

  always_comb begin
    events = '0;
    events[`ST_PARITY] = st.parity_evt;
    events[`ST_LOSS] = st.loss_evt;
    setup = psel & ~penable;
    wr = psel & penable & pready & pwrite;
    mapped = (paddr == `REG_STATUS) | (paddr == `REG_MASK) | (paddr == `REG_MODE);
    // an event in the clearing cycle survives the write-one-to-clear
    next_status = status | events;
    if (wr && paddr == `REG_STATUS) begin
      next_status = (status & ~pwdata[`ST_W-1:0]) | events;
    end
    next_mask = mask;
    if (wr && paddr == `REG_MASK) begin
      next_mask = pwdata[`ST_W-1:0];
    end
    next_pready = setup;
    next_pslverr = setup & ~mapped;
    next_prdata = prdata;
    if (setup && !pwrite) begin
      case (paddr)
        `REG_STATUS: next_prdata = 32'(status);
        `REG_MASK: next_prdata = 32'(mask);
        `REG_MODE: next_prdata = 32'({st.lane_count, st.mode});
        default: next_prdata = 32'h0000_0000;
      endcase
    end
    next_irq = |(status & mask);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      status <= '0;
      mask <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  property p_parity_sticky;
    st.parity_evt |=> status[`ST_PARITY] ##1 (status[`ST_PARITY] || $past(wr));
  endproperty
  a_parity_sticky: assert property (p_parity_sticky) else $error("parity status not set");
endmodule

/* rtl/serial_pixel_deserializer.sv */
// serial pixel deserializer: link sampling, framing, parity check, output bus, power modes
`include "serdes_defines.svh"
module serial_pixel_deserializer
  import serdes_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic link_clock_in,
  input wire logic serial_lane_zero,
  input wire logic serial_lane_one,
  input wire logic serial_lane_two,
  input wire logic lane_select_low,
  input wire logic lane_select_high,
  input wire logic receiver_enable_in,
  input wire logic bus_swap_in,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic [23:0] pixel_bus,
  output logic vertical_sync_out,
  output logic horizontal_sync_out,
  output logic display_enable_out,
  output logic pixel_clock_out,
  output logic parity_error_flag
);
  localparam int PW = `PERIOD_W;

  logic [7:0] pin_s1;
  logic [7:0] pin_s2;
  logic link_s;
  logic [2:0] lane_s;
  logic [2:0] lane_mid;
  logic [2:0] lane_late;
  logic ls_high_s;
  logic ls_low_s;
  logic receiver_enable_in_s;
  logic swap_s;

  // every pin passes two flops; the link clock is only sampled, never used as a clock
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
      lane_mid <= 3'h0;
      lane_late <= 3'h0;
    end else begin
      pin_s1 <= {link_clock_in, serial_lane_two, serial_lane_one, serial_lane_zero,
                 lane_select_high, lane_select_low, receiver_enable_in, bus_swap_in};
      pin_s2 <= pin_s1;
      // lanes trail the link clock by the start and strobe registers, so strobes land mid-bit
      lane_mid <= lane_s;
      lane_late <= lane_mid;
    end
  end
  assign {link_s, lane_s, ls_high_s, ls_low_s, receiver_enable_in_s, swap_s} = pin_s2;

  // link clock presence and period measurement
  logic link_d;
  logic [PW-1:0] idle_cnt;
  logic [PW-1:0] period;
  logic rise_seen;
  logic present;
  logic next_link_d;
  logic [PW-1:0] next_idle_cnt;
  logic [PW-1:0] next_period;
  logic next_rise_seen;
  logic next_present;
  logic link_rise;
  logic loss_evt;

  always_comb begin
    link_rise = link_s & ~link_d;
    next_link_d = link_s;
    next_idle_cnt = idle_cnt;
    next_period = period;
    next_rise_seen = rise_seen;
    next_present = present;
    loss_evt = 1'b0;
    if (!receiver_enable_in_s) begin
      next_idle_cnt = '0;
      next_rise_seen = 1'b0;
      next_present = 1'b0;
    end else if (link_rise) begin
      // one full period is needed before the bit timing can be trusted
      next_idle_cnt = '0;
      next_period = PW'(idle_cnt + PW'(1));
      next_rise_seen = 1'b1;
      next_present = rise_seen;
    end else if (idle_cnt == `LOSS_CYCLES) begin
      next_present = 1'b0;
      next_rise_seen = 1'b0;
      loss_evt = present;
    end else begin
      next_idle_cnt = PW'(idle_cnt + PW'(1));
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      link_d <= 1'b0;
      idle_cnt <= '0;
      period <= '0;
      rise_seen <= 1'b0;
      present <= 1'b0;
    end else begin
      link_d <= next_link_d;
      idle_cnt <= next_idle_cnt;
      period <= next_period;
      rise_seen <= next_rise_seen;
      present <= next_present;
    end
  end

  // power mode
  power_mode_t mode;
  power_mode_t next_mode;
  logic active;

  always_comb begin
    case (mode)
      PM_SHUTDOWN, PM_STANDBY, PM_ACTIVE: begin
        if (!receiver_enable_in_s) begin
          next_mode = PM_SHUTDOWN;
        end else if (!present) begin
          next_mode = PM_STANDBY;
        end else begin
          next_mode = PM_ACTIVE;
        end
      end
      default: next_mode = PM_SHUTDOWN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mode <= PM_SHUTDOWN;
    end else begin
      mode <= next_mode;
    end
  end
  assign active = (mode == PM_ACTIVE);

  // lane selection and frame gathering
  logic [1:0] lane_count;
  logic [4:0] bits_per_lane;
  logic strobe;
  logic last;

  always_comb begin
    if (ls_high_s) begin
      lane_count = 2'h3;
      bits_per_lane = `BITS_3LANE;
    end else if (ls_low_s) begin
      lane_count = 2'h2;
      bits_per_lane = `BITS_2LANE;
    end else begin
      lane_count = 2'h1;
      bits_per_lane = `BITS_1LANE;
    end
  end

  bit_timer #(.PW(PW)) u_bit_timer (
    .clock(clock),
    .srst(srst),
    .start(link_rise),
    .period(period),
    .bits_per_lane(bits_per_lane),
    .strobe(strobe),
    .last(last)
  );

  logic [`FRAME_BITS-1:0] shreg;
  logic [`FRAME_BITS-1:0] next_shreg;
  logic eval;
  logic next_eval;

  // lane zero carries the earliest bit of each group; unused lanes are not read
  always_comb begin
    next_shreg = shreg;
    if (strobe) begin
      case (lane_count)
        2'h3: next_shreg = {shreg[`FRAME_BITS-4:0], lane_late[0], lane_late[1], lane_late[2]};
        2'h2: next_shreg = {shreg[`FRAME_BITS-3:0], lane_late[0], lane_late[1]};
        default: next_shreg = {shreg[`FRAME_BITS-2:0], lane_late[0]};
      endcase
    end
    next_eval = strobe & last & active;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      shreg <= '0;
      eval <= 1'b0;
    end else begin
      shreg <= next_shreg;
      eval <= next_eval;
    end
  end

  // parity and output bus
  pixel_t payload;
  logic par_ok;
  logic [PW-1:0] half_cnt;
  logic [PW-1:0] next_half_cnt;
  logic [23:0] next_pixel_bus;
  logic next_vs;
  logic next_hs;
  logic next_de;
  logic next_pclk;
  logic next_perr;

  function automatic logic [23:0] order_colours(input pixel_t p, input logic swap);
    logic [23:0] rgb;
    logic [23:0] res;
    rgb = {p.red, p.green, p.blue};
    res = rgb;
    if (swap) begin
      for (int i = 0; i < 24; i++) begin
        res[i] = rgb[23-i];
      end
    end
    return res;
  endfunction

  always_comb begin
    payload = pixel_t'(shreg[`FR_PAY_HI:`FR_PAY_LO]);
    par_ok = ((^shreg[`FR_PAY_HI:`FR_PAR_BIT]) == `PARITY_SENSE);
    next_pixel_bus = pixel_bus;
    next_vs = vertical_sync_out;
    next_hs = horizontal_sync_out;
    next_de = display_enable_out;
    next_pclk = pixel_clock_out;
    next_perr = parity_error_flag;
    next_half_cnt = half_cnt;
    if (half_cnt != '0) begin
      next_half_cnt = PW'(half_cnt - PW'(1));
    end else begin
      next_pclk = 1'b0;
      next_perr = 1'b0;
    end
    if (!active) begin
      next_pixel_bus = 24'hff_ffff;
      next_vs = 1'b1;
      next_hs = 1'b1;
      next_de = 1'b0;
      next_pclk = 1'b0;
      next_perr = 1'b0;
      next_half_cnt = '0;
    end else if (eval) begin
      // the regenerated clock rises with the word and stays high half a period
      next_pclk = 1'b1;
      next_half_cnt = period >> 1;
      if (par_ok) begin
        next_pixel_bus = order_colours(payload, swap_s);
        next_vs = payload.vsync;
        next_hs = payload.hsync;
        next_de = payload.enable;
        next_perr = 1'b0;
      end else begin
        next_perr = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pixel_bus <= 24'hff_ffff;
      vertical_sync_out <= 1'b1;
      horizontal_sync_out <= 1'b1;
      display_enable_out <= 1'b0;
      pixel_clock_out <= 1'b0;
      parity_error_flag <= 1'b0;
      half_cnt <= '0;
    end else begin
      pixel_bus <= next_pixel_bus;
      vertical_sync_out <= next_vs;
      horizontal_sync_out <= next_hs;
      display_enable_out <= next_de;
      pixel_clock_out <= next_pclk;
      parity_error_flag <= next_perr;
      half_cnt <= next_half_cnt;
    end
  end

  status_if st ();
  assign st.parity_evt = eval & active & ~par_ok;
  assign st.loss_evt = loss_evt;
  assign st.mode = mode;
  assign st.lane_count = lane_count;

  apb_regs u_regs (
    .clock(clock),
    .srst(srst),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq(irq),
    .st(st.regs)
  );

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  property p_good_low;
    eval && active && par_ok |=> !parity_error_flag;
  endproperty
  a_good_low: assert property (p_good_low) else $error("error flag high on good frame");

  property p_bad_pulse;
    eval && active && !par_ok && receiver_enable_in_s && present |=> parity_error_flag && pixel_clock_out;
  endproperty
  a_bad_pulse: assert property (p_bad_pulse) else $error("no error pulse on bad frame");

  property p_bad_hold;
    eval && active && !par_ok && receiver_enable_in_s && present |=> $stable(pixel_bus) && $stable(display_enable_out);
  endproperty
  a_bad_hold: assert property (p_bad_hold) else $error("bad frame reached the bus");

  property p_good_latch;
    eval && active && par_ok && receiver_enable_in_s && present
      |=> display_enable_out == $past(shreg[`FR_PAY_LO]) && pixel_clock_out;
  endproperty
  a_good_latch: assert property (p_good_latch) else $error("good frame not latched");

  property p_swap_order;
    eval && active && par_ok && swap_s && receiver_enable_in_s && present
      |=> pixel_bus[23] == $past(shreg[`FR_BLUE0_BIT]);
  endproperty
  a_swap_order: assert property (p_swap_order) else $error("swapped order wrong");

  property p_idle_static;
    !active |=> !pixel_clock_out && !display_enable_out && (&pixel_bus)
      && vertical_sync_out && horizontal_sync_out;
  endproperty
  a_idle_static: assert property (p_idle_static) else $error("bus not static when idle");

  property p_shutdown;
    !receiver_enable_in_s |=> mode == PM_SHUTDOWN;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("no shutdown on enable low");

  property p_standby;
    receiver_enable_in_s && present && !link_rise && idle_cnt == `LOSS_CYCLES ##1 receiver_enable_in_s |=> mode == PM_STANDBY;
  endproperty
  a_standby: assert property (p_standby) else $error("no standby on clock loss");

  property p_one_lane;
    strobe && lane_count == 2'h1 |=> shreg[0] == $past(lane_late[0]);
  endproperty
  a_one_lane: assert property (p_one_lane) else $error("lane zero not shifted in");

  property p_three_lane;
    strobe && ls_high_s |=> shreg[0] == $past(lane_late[2]) && shreg[2] == $past(lane_late[0]);
  endproperty
  a_three_lane: assert property (p_three_lane) else $error("three lane shift wrong");

  property p_mode_onehot;
    $onehot(mode);
  endproperty
  a_mode_onehot: assert property (p_mode_onehot) else $error("mode not one-hot");

  c_good_frame: cover property (eval && active && par_ok);
  c_bad_frame: cover property (eval && active && !par_ok);
  c_three_lanes: cover property (eval && active && lane_count == 2'h3);
  c_standby: cover property (mode == PM_ACTIVE ##1 mode == PM_STANDBY);
endmodule

/* tb/link_tx_model.sv */
// transmitter model: forwarded pixel clock and one to three serial data lanes
module link_tx_model (
  output logic link_clk,
  output logic [2:0] lane
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [29:0] q[$];

  initial begin
    link_clk = 1'b0;
    lane = 3'h0;
  end

  // one forwarded clock period per queued frame; the clock stands low once the queue is empty
  task automatic run(input int n);
    real per;
    logic [29:0] f;
    // slower periods for fewer lanes keep every bit above one sample clock
    per = (n == 1) ? 250.0 : (n == 2) ? 150.0 : 100.0;
    // move every link edge off the block's sampling edge
    #1;
    while (q.size() > 0) begin
      f = q.pop_front();
      fork
        begin
          link_clk = 1'b1;
          #(per / 2.0);
          link_clk = 1'b0;
        end
        for (int s = 0; s < 30 / n; s++) begin
          lane[0] = f[29 - n * s];
          lane[1] = (n > 1) ? f[28 - n * s] : s[0];
          lane[2] = (n > 2) ? f[27 - n * s] : ~s[0];
          #(per * n / 30.0);
        end
      join
    end
    // released clock stays low; released lanes must not keep showing the last bit
    lane = ~lane;
  endtask
endmodule

/* tb/serial_pixel_deserializer_tb_top.sv */
// testbench for the serial pixel deserializer
`include "serdes_defines.svh"
module serial_pixel_deserializer_tb_top
  import serdes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock;
  logic srst = 1'b1;
  logic link_clock_in;
  logic [2:0] lanes;
  logic lane_select_low = 1'b0;
  logic lane_select_high = 1'b0;
  logic receiver_enable_in = 1'b1;
  logic bus_swap_in = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic [23:0] pixel_bus;
  logic vertical_sync_out, horizontal_sync_out, display_enable_out;
  logic pixel_clock_out, parity_error_flag;
  int error_cnt = 0;
  int tests_run = 0;
  logic [27:0] seen[$];
  logic pclk_q = 1'b0;
  logic [29:0] fq[$];

  serial_pixel_deserializer DUT (.clock(clock), .srst(srst), .link_clock_in(link_clock_in),
    .serial_lane_zero(lanes[0]), .serial_lane_one(lanes[1]), .serial_lane_two(lanes[2]),
    .lane_select_low(lane_select_low), .lane_select_high(lane_select_high),
    .receiver_enable_in(receiver_enable_in), .bus_swap_in(bus_swap_in), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .pixel_bus(pixel_bus),
    .vertical_sync_out(vertical_sync_out), .horizontal_sync_out(horizontal_sync_out),
    .display_enable_out(display_enable_out), .pixel_clock_out(pixel_clock_out),
    .parity_error_flag(parity_error_flag));

  link_tx_model tx (.link_clk(link_clock_in), .lane(lanes));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // one word captured per regenerated pixel clock rise
  always @(posedge clock) begin
    if (pixel_clock_out === 1'b1 && pclk_q === 1'b0) begin
      seen.push_back({pixel_bus, vertical_sync_out, horizontal_sync_out,
        display_enable_out, parity_error_flag});
    end
    pclk_q <= pixel_clock_out;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clock);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do @(posedge clock); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) error_cnt++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(a, 1'b0, 32'h0000_0000, r, e);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask

  function automatic logic [29:0] mkf(input logic [26:0] pay, input logic bad);
    return {1'b1, pay, ~(^pay) ^ bad, 1'b0};
  endfunction

  function automatic logic [27:0] expw(input logic [29:0] f, input logic sw);
    logic [23:0] px;
    px = f[28:5];
    if (sw) begin
      px = {<<{px}};
    end
    return {px, f[4:2], 1'b0};
  endfunction

  task automatic idle_chk;
    check(32'({pixel_clock_out, display_enable_out, pixel_bus, vertical_sync_out,
      horizontal_sync_out}), 32'h03ff_ffff);
  endtask

  // three filler frames cover activation after a gap, then the queued frames are judged
  task automatic send(input logic [1:0] ls, input logic sw, input logic on);
    int n;
    int base;
    logic [27:0] e[$];
    logic [27:0] last;
    logic [29:0] fill;
    logic [31:0] r;
    n = ls[1] ? 3 : ls[0] ? 2 : 1;
    @(posedge clock);
    lane_select_low <= ls[0];
    lane_select_high <= ls[1];
    bus_swap_in <= sw;
    fill = mkf(27'h2a5_c3f1, 1'b0);
    last = expw(fill, sw);
    for (int i = 0; i < 3; i++) tx.q.push_back(fill);
    foreach (fq[i]) begin
      tx.q.push_back(fq[i]);
      if (^fq[i][28:1]) begin
        last = expw(fq[i], sw);
        e.push_back(last);
      end else begin
        e.push_back({last[27:1], 1'b1});
      end
    end
    base = seen.size();
    fork
      tx.run(n);
      begin
        repeat (n == 1 ? 150 : n == 2 ? 90 : 60) @(posedge clock);
        rd(`REG_MODE, r);
        check(32'(r[2:0]), 32'(on ? PM_ACTIVE : PM_SHUTDOWN));
      end
    join
    repeat (80) @(posedge clock);
    if (on) begin
      check(32'(seen.size() - base >= e.size()), 32'h0000_0001);
      foreach (e[i]) check(32'(seen[seen.size() - e.size() + i]), 32'(e[i]));
    end else begin
      check(32'(seen.size() - base), 32'h0000_0000);
    end
    fq.delete();
  endtask

  task automatic t_regs;
    logic [31:0] r;
    logic e;
    rd(`REG_STATUS, r);
    check(r, 32'h0000_0000);
    apb(12'h010, 1'b0, 32'h0000_0000, r, e);
    check({r[30:0], e}, 32'h0000_0001);
    wr(`REG_MASK, 32'h0000_0003);
    rd(`REG_MASK, r);
    check(r, 32'h0000_0003);
    wr(`REG_MASK, 32'h0000_0000);
    idle_chk();
  endtask

  task automatic t_lanes;
    logic [26:0] pat[4] = '{27'h000_0000, 27'h123_4567, 27'h5a5_a5a5, 27'h6db_6db6};
    for (int k = 0; k < 4; k++) begin
      fq = {mkf(pat[k], 1'b0), mkf(~pat[k], 1'b0)};
      send(2'(k), 1'b0, 1'b1);
    end
  endtask

  task automatic t_parity;
    logic [31:0] r;
    wr(`REG_MASK, 32'h0000_0001);
    wr(`REG_STATUS, 32'h0000_0003);
    fq = {mkf(27'h111_1111, 1'b0), mkf(27'h222_2222, 1'b1), mkf(27'h333_3333, 1'b0),
      mkf(27'h444_4444, 1'b1), mkf(27'h555_5555, 1'b1)};
    send(2'b10, 1'b0, 1'b1);
    rd(`REG_STATUS, r);
    check(32'({r[0], irq}), 32'h0000_0003);
    wr(`REG_STATUS, 32'h0000_0001);
    repeat (3) @(posedge clock);
    rd(`REG_STATUS, r);
    check(32'({r[0], irq}), 32'h0000_0000);
  endtask

  task automatic t_swap;
    fq = {mkf(27'h0f0_3c5a, 1'b0), mkf(27'h7c3_81e6, 1'b1), mkf(27'h3a9_9e17, 1'b0)};
    send(2'b10, 1'b1, 1'b1);
  endtask

  task automatic t_loss;
    logic [31:0] r;
    repeat (150) @(posedge clock);
    idle_chk();
    rd(`REG_MODE, r);
    check(32'(r[2:0]), 32'(PM_STANDBY));
    wr(`REG_MASK, 32'h0000_0002);
    rd(`REG_STATUS, r);
    check(32'({r[1], irq}), 32'h0000_0003);
    wr(`REG_STATUS, 32'h0000_0002);
    repeat (3) @(posedge clock);
    check(32'(irq), 32'h0000_0000);
    wr(`REG_MASK, 32'h0000_0000);
  endtask

  task automatic t_shut;
    @(posedge clock);
    receiver_enable_in <= 1'b0;
    fq = {mkf(27'h0ff_00ff, 1'b0)};
    send(2'b10, 1'b0, 1'b0);
    @(posedge clock);
    receiver_enable_in <= 1'b1;
    fq = {mkf(27'h00f_f0f0, 1'b0)};
    send(2'b10, 1'b0, 1'b1);
  endtask

  // whole run is near 10 us; the limit leaves ample margin
  initial begin
    #100_000;
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    t_regs();
    t_lanes();
    t_parity();
    t_swap();
    t_loss();
    t_shut();
    conclude();
  end
endmodule
